/* verilog/csp_defs.svh */
// offsets, bit positions, reset values and counts of the clock select block
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

`define CSP_IDX_CLKS      8'h39
`define CSP_IDX_PLL       8'h3A
`define CSP_IDX_STAT      8'h3C

`define CSP_BIT_SYS_PLL   3'd7
`define CSP_BIT_STOP_KEEP 3'd6
`define CSP_BIT_TMR_STOP  3'd3
`define CSP_BIT_WD_STOP   3'd2
`define CSP_BIT_TMR_OSC   3'd1
`define CSP_BIT_WD_OSC    3'd0
`define CSP_BIT_MOD_HI    3'd5
`define CSP_BIT_MOD_LO    3'd4

`define CSP_CLKS_RESET    8'h80
`define CSP_PLL_RESET     8'h00
`define CSP_CLKS_WMASK_N  8'hCF
`define CSP_PLL_WMASK     8'h30

`define CSP_FM_REF_DIV    16
`define CSP_FM_HALF       ((`CSP_FM_REF_DIV) / 2)

`define CSP_RESP_OKAY     2'h0
`define CSP_RESP_SLVERR   2'h2

`endif

/* verilog/csp_pkg.sv */
// types of the clock select block
package csp_pkg;
	typedef logic [7:0] csp_byte_t;
	typedef logic [11:0] csp_addr_t;
	typedef enum logic [3:0] {
		CSP_FM_OFF = 4'h1,
		CSP_FM_1PC = 4'h2,
		CSP_FM_2PC = 4'h4,
		CSP_FM_4PC = 4'h8
	} csp_fm_e;
endpackage

/* verilog/csp_sync3.sv */
// three-stage synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module csp_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output      logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q      <= '0;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (s2_reg[i] == s3_reg[i])
					q[i] <= s3_reg[i];
			end
		end
	end
endmodule

/* verilog/csp_clock_ctrl.sv */
// clock select and pll modulation control with axi4-lite registers
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_clock_ctrl (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire csp_pkg::csp_addr_t S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output      logic              S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output      logic              S_AXI_WREADY,
	output      logic [1:0]        S_AXI_BRESP,
	output      logic              S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire csp_pkg::csp_addr_t S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output      logic              S_AXI_ARREADY,
	output      logic [31:0]       S_AXI_RDATA,
	output      logic [1:0]        S_AXI_RRESP,
	output      logic              S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic              SPECIAL_MODE,
	input  wire logic              WRITE_PROTECT,
	input  wire logic              WDOG_ONCE_TAKEN,
	input  wire logic              STOP_ACTIVE,
	input  wire logic              OSC_QUALIFIED,
	input  wire logic              PLL_LOCK_IN,
	input  wire logic              REF_CLK_IN,
	output      logic              BUS_SRC_PLL,
	output      logic              OSC_ENABLE,
	output      logic              TIMER_SRC_OSC,
	output      logic              WDOG_SRC_OSC,
	output      logic              TIMER_RUN,
	output      logic              WDOG_RUN,
	output      logic              TIMER_RESTART,
	output      logic              WDOG_RESTART,
	output      logic              STATUS_CLEAR,
	output      csp_pkg::csp_fm_e  MOD_AMP,
	output      logic              MOD_PHASE
);
	import csp_pkg::*;

	csp_byte_t   clks_reg;
	csp_byte_t   clks_next;
	csp_byte_t   pll_reg;
	logic        lock_reg;
	logic        osc_up_reg;
	logic        osc_up_next;
	logic        qual_all_prev_reg;
	logic        stop_prev_reg;
	logic        wd_once_reg;
	logic        wd_retry_reg;
	logic        aw_rdy_reg;
	logic        ar_rdy_reg;
	logic        lock_s;
	logic        qual_s;
	logic        ref_s;
	logic        ref_prev_reg;
	logic [3:0]  fm_cnt_reg;
	logic        clks_we;
	logic        pll_we;
	logic        stat_hit_w;
	logic        full_stop_entry;
	logic        osc_fall;
	logic        qual_all;
	logic        wd_writable;
	csp_byte_t   wd;
	csp_byte_t   rd_byte;
	logic        rd_hit;

	csp_sync3 #(.WIDTH(3)) u_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     ({PLL_LOCK_IN, OSC_QUALIFIED, REF_CLK_IN}),
		.q     ({lock_s, qual_s, ref_s})
	);

	// write channel decode; address and data taken together
	assign wd = S_AXI_WDATA[7:0];
	assign stat_hit_w = S_AXI_AWADDR == {2'h0, `CSP_IDX_STAT, 2'h0};
	assign clks_we = aw_rdy_reg && S_AXI_WSTRB[0] && !WRITE_PROTECT
		&& S_AXI_AWADDR == {2'h0, `CSP_IDX_CLKS, 2'h0};
	assign pll_we = aw_rdy_reg && S_AXI_WSTRB[0] && !WRITE_PROTECT
		&& clks_reg[`CSP_BIT_SYS_PLL]
		&& S_AXI_AWADDR == {2'h0, `CSP_IDX_PLL, 2'h0};

	assign full_stop_entry = STOP_ACTIVE && !stop_prev_reg
		&& !clks_reg[`CSP_BIT_STOP_KEEP];
	assign qual_all = qual_s && lock_s && lock_reg
		&& !(STOP_ACTIVE && !clks_reg[`CSP_BIT_STOP_KEEP]);

	// oscillator-up status, read-only, lost with lock except in pseudo stop
	always_comb
	begin
		osc_up_next = osc_up_reg;
		if (!qual_s || full_stop_entry || pll_we)
			osc_up_next = 1'b0;
		if (!lock_s && !(STOP_ACTIVE && clks_reg[`CSP_BIT_STOP_KEEP]))
			osc_up_next = 1'b0;
		if (qual_all && !qual_all_prev_reg && !pll_we)
			osc_up_next = 1'b1;
	end
	assign osc_fall = osc_up_reg && !osc_up_next;

	assign wd_writable = SPECIAL_MODE || !wd_once_reg || wd_retry_reg;

	always_comb
	begin
		clks_next = clks_reg;
		if (clks_we)
		begin
			clks_next[`CSP_BIT_SYS_PLL] = wd[7] || !osc_up_reg;
			clks_next[`CSP_BIT_STOP_KEEP] = wd[6];
			clks_next[`CSP_BIT_TMR_STOP] = wd[3];
			clks_next[`CSP_BIT_WD_STOP] = wd[2];
			clks_next[`CSP_BIT_TMR_OSC] = wd[1] && osc_up_reg;
			if (wd_writable)
				clks_next[`CSP_BIT_WD_OSC] = wd[0] && osc_up_reg;
			if (SPECIAL_MODE)
			begin
				clks_next[5] = 1'b0;
				clks_next[4] = 1'b0;
			end
		end
		if (osc_fall || full_stop_entry)
			clks_next[`CSP_BIT_SYS_PLL] = 1'b1;
		if (osc_fall)
		begin
			clks_next[`CSP_BIT_TMR_OSC] = 1'b0;
			clks_next[`CSP_BIT_WD_OSC] = 1'b0;
		end
		clks_next = clks_next & `CSP_CLKS_WMASK_N;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			clks_reg <= `CSP_CLKS_RESET;
		else
			clks_reg <= clks_next;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			pll_reg <= `CSP_PLL_RESET;
		else if (pll_we)
			pll_reg <= wd & `CSP_PLL_WMASK;
	end

	// lock status: follows lock, cleared by pll write for one cycle, set again next cycle while lock stays high
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			lock_reg          <= 1'b0;
			osc_up_reg        <= 1'b0;
			qual_all_prev_reg <= 1'b0;
			stop_prev_reg     <= 1'b0;
		end
		else
		begin
			if (!lock_s || pll_we)
				lock_reg <= 1'b0;
			else if (lock_s && !lock_reg && !pll_we)
				lock_reg <= 1'b1;
			osc_up_reg        <= osc_up_next;
			qual_all_prev_reg <= qual_all;
			stop_prev_reg     <= STOP_ACTIVE;
		end
	end

	// watchdog write-once tracking with one retry after oscillator loss
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wd_once_reg  <= 1'b0;
			wd_retry_reg <= 1'b0;
		end
		else
		begin
			if (WDOG_ONCE_TAKEN)
				wd_once_reg <= 1'b1;
			if (osc_fall && clks_reg[`CSP_BIT_WD_OSC] && wd_once_reg)
				wd_retry_reg <= 1'b1;
			else if (clks_we && !SPECIAL_MODE && wd_once_reg
				&& clks_next[`CSP_BIT_WD_OSC])
				wd_retry_reg <= 1'b0;
		end
	end

	// clock source and run enables toward the clock tree and timers
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			BUS_SRC_PLL   <= 1'b1;
			OSC_ENABLE    <= 1'b1;
			TIMER_SRC_OSC <= 1'b0;
			WDOG_SRC_OSC  <= 1'b0;
			TIMER_RUN     <= 1'b1;
			WDOG_RUN      <= 1'b1;
			TIMER_RESTART <= 1'b0;
			WDOG_RESTART  <= 1'b0;
			STATUS_CLEAR  <= 1'b0;
		end
		else
		begin
			BUS_SRC_PLL <= clks_next[`CSP_BIT_SYS_PLL]
				|| !osc_up_next;
			OSC_ENABLE <= !STOP_ACTIVE
				|| clks_next[`CSP_BIT_STOP_KEEP];
			TIMER_SRC_OSC <= clks_next[`CSP_BIT_TMR_OSC];
			WDOG_SRC_OSC  <= clks_next[`CSP_BIT_WD_OSC];
			TIMER_RUN <= !STOP_ACTIVE
				|| (clks_next[`CSP_BIT_STOP_KEEP]
				&& clks_next[`CSP_BIT_TMR_STOP]
				&& clks_next[`CSP_BIT_TMR_OSC]);
			WDOG_RUN <= !STOP_ACTIVE
				|| (clks_next[`CSP_BIT_STOP_KEEP]
				&& clks_next[`CSP_BIT_WD_STOP]
				&& clks_next[`CSP_BIT_WD_OSC]);
			TIMER_RESTART <= clks_next[`CSP_BIT_TMR_OSC]
				!= clks_reg[`CSP_BIT_TMR_OSC];
			WDOG_RESTART <= clks_next[`CSP_BIT_WD_OSC]
				!= clks_reg[`CSP_BIT_WD_OSC];
			STATUS_CLEAR <= pll_we;
		end
	end

	// modulation amplitude and fref/16 modulation phase
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			MOD_AMP      <= CSP_FM_OFF;
			MOD_PHASE    <= 1'b0;
			fm_cnt_reg   <= 4'h0;
			ref_prev_reg <= 1'b0;
		end
		else
		begin
			case (pll_reg[`CSP_BIT_MOD_HI:`CSP_BIT_MOD_LO])
				2'h0:    MOD_AMP <= CSP_FM_OFF;
				2'h1:    MOD_AMP <= CSP_FM_1PC;
				2'h2:    MOD_AMP <= CSP_FM_2PC;
				2'h3:    MOD_AMP <= CSP_FM_4PC;
				default: MOD_AMP <= CSP_FM_OFF;
			endcase
			ref_prev_reg <= ref_s;
			if (pll_reg[`CSP_BIT_MOD_HI:`CSP_BIT_MOD_LO] == 2'h0)
			begin
				fm_cnt_reg <= 4'h0;
				MOD_PHASE  <= 1'b0;
			end
			else if (ref_s && !ref_prev_reg)
			begin
				if (fm_cnt_reg == 4'(`CSP_FM_HALF - 1))
				begin
					fm_cnt_reg <= 4'h0;
					MOD_PHASE  <= !MOD_PHASE;
				end
				else
					fm_cnt_reg <= fm_cnt_reg + 4'h1;
			end
		end
	end

	// axi4-lite write path
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			aw_rdy_reg   <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `CSP_RESP_OKAY;
		end
		else
		begin
			aw_rdy_reg <= !aw_rdy_reg && !S_AXI_BVALID
				&& S_AXI_AWVALID && S_AXI_WVALID;
			if (aw_rdy_reg)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (S_AXI_AWADDR == {2'h0, `CSP_IDX_CLKS, 2'h0}
					|| S_AXI_AWADDR == {2'h0, `CSP_IDX_PLL, 2'h0}
					|| stat_hit_w) ? `CSP_RESP_OKAY : `CSP_RESP_SLVERR;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end
	assign S_AXI_AWREADY = aw_rdy_reg;
	assign S_AXI_WREADY  = aw_rdy_reg;

	// axi4-lite read path
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		if (S_AXI_ARADDR == {2'h0, `CSP_IDX_CLKS, 2'h0})
			rd_byte = clks_reg;
		else if (S_AXI_ARADDR == {2'h0, `CSP_IDX_PLL, 2'h0})
			rd_byte = pll_reg & `CSP_PLL_WMASK;
		else if (S_AXI_ARADDR == {2'h0, `CSP_IDX_STAT, 2'h0})
			rd_byte = {1'b0, STOP_ACTIVE, WRITE_PROTECT, SPECIAL_MODE,
				wd_retry_reg, wd_once_reg, lock_reg, osc_up_reg};
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ar_rdy_reg   <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= `CSP_RESP_OKAY;
		end
		else
		begin
			ar_rdy_reg <= !ar_rdy_reg && !S_AXI_RVALID && S_AXI_ARVALID;
			if (ar_rdy_reg)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= {24'h000000, rd_byte};
				S_AXI_RRESP  <= rd_hit ? `CSP_RESP_OKAY : `CSP_RESP_SLVERR;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
	assign S_AXI_ARREADY = ar_rdy_reg;
endmodule

/* tb/csp_clock_ctrl_monitor.sv */
// assertion checker for the clock select block
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_clock_ctrl_monitor (
	input wire logic               CLK,
	input wire logic               RST_N,
	input wire csp_pkg::csp_addr_t S_AXI_AWADDR,
	input wire logic               S_AXI_AWVALID,
	input wire logic               S_AXI_AWREADY,
	input wire logic [3:0]         S_AXI_WSTRB,
	input wire logic               S_AXI_WVALID,
	input wire logic               WRITE_PROTECT,
	input wire logic               STOP_ACTIVE,
	input wire logic               OSC_QUALIFIED,
	input wire logic               BUS_SRC_PLL,
	input wire logic               OSC_ENABLE,
	input wire logic               TIMER_SRC_OSC,
	input wire logic               WDOG_SRC_OSC,
	input wire logic               TIMER_RUN,
	input wire logic               WDOG_RUN,
	input wire logic               TIMER_RESTART,
	input wire logic               WDOG_RESTART,
	input wire logic               STATUS_CLEAR,
	input wire csp_pkg::csp_fm_e   MOD_AMP,
	input wire logic               MOD_PHASE
);
	import csp_pkg::*;
	localparam csp_addr_t PLL_ADDR = {2'b00, `CSP_IDX_PLL, 2'b00};
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	sequence pll_take;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
			&& S_AXI_AWADDR == PLL_ADDR;
	endsequence
	sequence pll_ok;
		pll_take ##0 (S_AXI_WSTRB[0] && !WRITE_PROTECT && BUS_SRC_PLL);
	endsequence
	a_pll_clear: assert property (
		pll_ok |-> ##[1:3] STATUS_CLEAR)
		else $error("status clear missing after pll write");
	a_pll_refuse: assert property (
		pll_take ##0 (WRITE_PROTECT || !BUS_SRC_PLL) |=> !STATUS_CLEAR [*3])
		else $error("refused pll write cleared status");
	a_amp_onehot: assert property ($onehot(MOD_AMP))
		else $error("amplitude not one-hot");
	a_phase_off: assert property (
		(MOD_AMP == CSP_FM_OFF) [*2] |-> !MOD_PHASE)
		else $error("modulation clock runs while off");
	a_tmr_restart: assert property (
		$changed(TIMER_SRC_OSC) |-> ##[0:2] TIMER_RESTART)
		else $error("timer restart missing");
	a_wd_restart: assert property (
		$changed(WDOG_SRC_OSC) |-> ##[0:2] WDOG_RESTART)
		else $error("watchdog restart missing");
	a_tmr_freeze: assert property (
		(STOP_ACTIVE && !TIMER_SRC_OSC) [*3] |-> !TIMER_RUN)
		else $error("timer runs in stop");
	a_wd_freeze: assert property (
		(STOP_ACTIVE && !WDOG_SRC_OSC) [*3] |-> !WDOG_RUN)
		else $error("watchdog runs in stop");
	a_osc_run: assert property ((!STOP_ACTIVE) [*3] |-> OSC_ENABLE)
		else $error("oscillator off outside stop");
	a_osc_loss: assert property (
		(!OSC_QUALIFIED) [*8] |-> BUS_SRC_PLL && !TIMER_SRC_OSC
			&& !WDOG_SRC_OSC)
		else $error("sources not forced on oscillator loss");
endmodule
bind csp_clock_ctrl csp_clock_ctrl_monitor u_mon (
	.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
	.WRITE_PROTECT(WRITE_PROTECT), .STOP_ACTIVE(STOP_ACTIVE),
	.OSC_QUALIFIED(OSC_QUALIFIED), .BUS_SRC_PLL(BUS_SRC_PLL),
	.OSC_ENABLE(OSC_ENABLE), .TIMER_SRC_OSC(TIMER_SRC_OSC),
	.WDOG_SRC_OSC(WDOG_SRC_OSC), .TIMER_RUN(TIMER_RUN), .WDOG_RUN(WDOG_RUN),
	.TIMER_RESTART(TIMER_RESTART), .WDOG_RESTART(WDOG_RESTART),
	.STATUS_CLEAR(STATUS_CLEAR), .MOD_AMP(MOD_AMP), .MOD_PHASE(MOD_PHASE));

/* tb/tb.sv */
// self-checking bench for the clock select block
`timescale 1ns/1ps
`include "csp_defs.svh"
module tb;
	import csp_pkg::*;
	localparam csp_addr_t A_CLKS = {2'b00, `CSP_IDX_CLKS, 2'b00};
	localparam csp_addr_t A_PLL = {2'b00, `CSP_IDX_PLL, 2'b00};
	localparam csp_addr_t A_STAT = {2'b00, `CSP_IDX_STAT, 2'b00};
	localparam int REF_CYC = 16;
	logic        clk = 0, rst_n = 0, aw_valid = 0, w_valid = 0, b_ready = 0;
	logic        ar_valid = 0, r_ready = 0, special = 0, write_protect = 0, once = 0;
	logic        stop = 0, qual = 0, lock = 0, ref_clk = 0;
	csp_addr_t   aw_addr = '0, ar_addr = '0;
	logic [31:0] w_data = '0;
	logic [3:0]  w_strb = '0;
	logic [2:0]  rc = '0;
	logic [7:0]  d;
	wire         aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, bus_pll, osc_en;
	wire         t_osc, w_osc, t_run, w_run, t_rst, w_rst, st_clr, phase;
	wire [1:0]   b_resp, r_resp;
	wire [31:0]  r_data;
	csp_fm_e     amp;
	int          mismatches = 0, checks_done = 0;
	csp_clock_ctrl DUT (
		.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(aw_addr),
		.S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_rdy),
		.S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
		.S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
		.S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
		.S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_rdy),
		.S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
		.S_AXI_RREADY(r_ready), .SPECIAL_MODE(special), .WRITE_PROTECT(write_protect),
		.WDOG_ONCE_TAKEN(once), .STOP_ACTIVE(stop), .OSC_QUALIFIED(qual),
		.PLL_LOCK_IN(lock), .REF_CLK_IN(ref_clk), .BUS_SRC_PLL(bus_pll),
		.OSC_ENABLE(osc_en), .TIMER_SRC_OSC(t_osc), .WDOG_SRC_OSC(w_osc),
		.TIMER_RUN(t_run), .WDOG_RUN(w_run), .TIMER_RESTART(t_rst),
		.WDOG_RESTART(w_rst), .STATUS_CLEAR(st_clr), .MOD_AMP(amp),
		.MOD_PHASE(phase));
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		rc <= rc + 3'h1;
		if (rc == 3'h7)
			ref_clk <= ~ref_clk;
	end
	function automatic logic [31:0] fm(input logic [1:0] k);
		return 32'h1 << k;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic phase_chk;
		int n;
		logic p;
		n = 0;
		for (int j = 0; j < 2; j++)
		begin
			n = 0;
			p = phase;
			while (phase === p && n < 400)
			begin
				wt(1);
				n++;
			end
		end
		chk("MOD_PHASE", 32'(`CSP_FM_REF_DIV / 2 * REF_CYC), n);
	endtask
	task automatic wr(input csp_addr_t a, input logic [7:0] v,
		input logic [1:0] rs, input logic s);
		@(posedge clk);
		aw_addr <= a;
		w_data <= ($urandom() << 8) | {24'h0, v};
		w_strb <= (4'($urandom()) & 4'hE) | {3'h0, s};
		aw_valid <= 1;
		w_valid <= 1;
		b_ready <= 1;
		do
		begin
			@(posedge clk);
			if (aw_rdy)
				aw_valid <= 0;
			if (w_rdy)
				w_valid <= 0;
		end
		while (b_valid !== 1'b1);
		b_ready <= 0;
		chk("BRESP", {30'h0, rs}, {30'h0, b_resp});
	endtask
	task automatic rd(input csp_addr_t a, input logic [31:0] e, m,
		input logic [1:0] rs);
		@(posedge clk);
		ar_addr <= a;
		ar_valid <= 1;
		r_ready <= 1;
		do
		begin
			@(posedge clk);
			if (ar_rdy)
				ar_valid <= 0;
		end
		while (r_valid !== 1'b1);
		r_ready <= 0;
		chk("RDATA", e, r_data & m);
		chk("RRESP", {30'h0, rs}, {30'h0, r_resp});
	endtask
	task automatic osc_on;
		qual <= 1;
		lock <= 0;
		wt(6);
		lock <= 1;
		wt(12);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(64060));
		wt(20);
		rst_n <= 1;
		rd(A_CLKS, 32'h80, '1, 0);
		rd(A_PLL, 32'h00, '1, 0);
		rd(12'h100, 32'h0, '1, `CSP_RESP_SLVERR);
		wr(12'h100, 8'hFF, `CSP_RESP_SLVERR, 1);
		wr(A_CLKS, 8'h4F, 0, 1);
		rd(A_CLKS, 32'hCC, '1, 0);
		write_protect <= 1;
		wr(A_CLKS, 8'h00, 0, 1);
		wr(A_PLL, 8'h30, 0, 1);
		chk("STATUS_CLEAR", 0, {31'h0, st_clr});
		write_protect <= 0;
		rd(A_CLKS, 32'hCC, '1, 0);
		rd(A_PLL, 32'h00, '1, 0);
		wr(A_CLKS, 8'h80, 0, 0);
		rd(A_CLKS, 32'hCC, '1, 0);
		for (int k = 0; k < 4; k++)
		begin
			d = 8'($urandom());
			d[5:4] = k[1:0];
			wr(A_PLL, d, 0, 1);
			chk("STATUS_CLEAR", 1, {31'h0, st_clr});
			rd(A_PLL, {26'h0, k[1:0], 4'h0}, '1, 0);
			chk("MOD_AMP", fm(k[1:0]), {28'h0, amp});
		end
		phase_chk();
		wr(A_PLL, 8'h00, 0, 1);
		rd(A_PLL, 32'h00, '1, 0);
		chk("MOD_AMP", fm(2'h0), {28'h0, amp});
		chk("MOD_PHASE", 0, {31'h0, phase});
		osc_on();
		rd(A_STAT, 32'h03, '1, 0);
		wr(A_CLKS, 8'h03, 0, 1);
		chk("TIMER_RESTART", 1, {31'h0, t_rst});
		chk("WDOG_RESTART", 1, {31'h0, w_rst});
		rd(A_CLKS, 32'h03, '1, 0);
		chk("BUS_SRC_PLL", 0, {31'h0, bus_pll});
		chk("TIMER_SRC_OSC", 1, {31'h0, t_osc});
		wr(A_PLL, 8'h30, 0, 1);
		chk("STATUS_CLEAR", 0, {31'h0, st_clr});
		rd(A_PLL, 32'h00, '1, 0);
		once <= 1;
		wt(1);
		once <= 0;
		wr(A_CLKS, 8'h02, 0, 1);
		rd(A_CLKS, 32'h03, '1, 0);
		qual <= 0;
		wt(12);
		rd(A_CLKS, 32'h80, '1, 0);
		osc_on();
		wr(A_CLKS, 8'h01, 0, 1);
		rd(A_CLKS, 32'h01, '1, 0);
		wr(A_CLKS, 8'h00, 0, 1);
		rd(A_CLKS, 32'h01, '1, 0);
		special <= 1;
		for (int k = 0; k < 4; k++)
		begin
			d = 8'($urandom());
			wr(A_CLKS, d, 0, 1);
			rd(A_CLKS, {24'h0, d & 8'hCF}, '1, 0);
		end
		wr(A_CLKS, 8'h4F, 0, 1);
		stop <= 1;
		wt(4);
		chk("OSC_ENABLE", 1, {31'h0, osc_en});
		chk("TIMER_RUN", 1, {31'h0, t_run});
		chk("WDOG_RUN", 1, {31'h0, w_run});
		stop <= 0;
		wt(4);
		wr(A_CLKS, 8'h0F, 0, 1);
		stop <= 1;
		wt(12);
		chk("OSC_ENABLE", 0, {31'h0, osc_en});
		chk("TIMER_RUN", 0, {31'h0, t_run});
		chk("BUS_SRC_PLL", 1, {31'h0, bus_pll});
		chk("WDOG_SRC_OSC", 0, {31'h0, w_osc});
		chk("WDOG_RUN", 0, {31'h0, w_run});
		give_verdict();
	end
endmodule
